// ==== logic/csrc_defines.svh ====
`ifndef CSRC_DEFINES_SVH
`define CSRC_DEFINES_SVH

// output pin selector
`define CSRC_SEL_W 6
`define CSRC_SEL_CARRIER 6'h0E
`define CSRC_SEL_CLK192 6'h3F
`define CSRC_SEL_RESET `CSRC_SEL_CLK192
`define CSRC_CLK_DIV 192
`define CSRC_CLK_HALF 8'h60

// rssi arithmetic, half-dB units
`define CSRC_RSSI_OFFSET_HDB 148
`define CSRC_HYST_HDB 10'sh002
`define CSRC_REL_STEP_6DB 10'sh00C
`define CSRC_REL_STEP_10DB 10'sh014
`define CSRC_REL_STEP_14DB 10'sh01C
`define CSRC_ABS_LEVEL_MIN 4'h9
`define CSRC_GOAL_SPLIT 3'h5

// sync qualifier field
`define CSRC_SYNC_CS_BIT 2

// controller state numbers
`define CSRC_STNUM_STARTUP 5'h00
`define CSRC_STNUM_IDLE 5'h01
`define CSRC_STNUM_RX 5'h0D
`define CSRC_STNUM_RX_OVF 5'h11

// timing
`define CSRC_MCLK_PERIOD_NS 50
`define CSRC_XOSC_SETTLE_NS 100000
`define CSRC_XOSC_SETTLE_CYC ((`CSRC_XOSC_SETTLE_NS + `CSRC_MCLK_PERIOD_NS - 1) / `CSRC_MCLK_PERIOD_NS)
`define CSRC_RESET_COMMAND_STROBE_BUSY_CYC 4

`endif

// ==== logic/csrc_pkg.sv ====
`default_nettype none
package csrc_pkg;

	typedef enum logic [1:0] {
		CSRC_REL_OFF,
		CSRC_REL_6DB,
		CSRC_REL_10DB,
		CSRC_REL_14DB
	} csrc_rel_step_e;

	typedef enum logic [1:0] {
		CSRC_ST_STARTUP,
		CSRC_ST_IDLE,
		CSRC_ST_RX,
		CSRC_ST_RX_OVF
	} csrc_state_e;

	typedef struct packed {
		logic [2:0] modem_config_two_sync_mode;
		logic [2:0] front_gain_ceiling;
		logic [1:0] digital_gain_ceiling;
		logic [3:0] absolute_detect_level;
		csrc_rel_step_e relative_detect_step;
		logic [2:0] channel_level_goal;
	} csrc_cfg_s;

	typedef struct packed {
		logic [4:0] controller_state_number;
		logic packet_status_carrier_bit;
		logic device_not_ready_flag;
	} csrc_status_s;

endpackage
`default_nettype wire

// ==== logic/csrc_core.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "csrc_defines.svh"

module csrc_core (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire csrc_pkg::csrc_cfg_s i_cfg,
	input wire logic i_rssi_valid,
	input wire logic [7:0] i_rssi,
	input wire logic i_reset_command_strobe,
	input wire logic i_cmd_rx,
	input wire logic i_cmd_idle,
	input wire logic i_cmd_flush_rx,
	input wire logic i_rx_fifo_overflow,
	input wire logic i_output_pin_selector_wr,
	input wire logic [5:0] i_output_pin_selector,
	input wire logic i_chip_select_low_n,
	output logic o_serial_out,
	output logic o_serial_out_oe,
	output logic o_general_output_pin_zero,
	output logic [5:0] o_output_pin_selector,
	output logic o_sync_search_en,
	output csrc_pkg::csrc_status_s o_status
);

	// typical threshold in dBm, half-dB units, index {front, digital}
	// one row per front ceiling, digital ceiling across
	localparam int THR_GOAL3 [32] = '{
		-195, -183, -171, -159,
		-188, -176, -165, -152,
		-181, -169, -157, -145,
		-176, -165, -153, -141,
		-171, -160, -147, -136,
		-168, -156, -144, -132,
		-164, -152, -140, -128,
		-158, -147, -134, -122
	};
	localparam int THR_GOAL7 [32] = '{
		-181, -169, -157, -145,
		-176, -164, -152, -140,
		-169, -157, -144, -132,
		-165, -153, -140, -128,
		-161, -149, -136, -124,
		-156, -144, -132, -120,
		-153, -140, -128, -116,
		-149, -136, -124, -112
	};
	localparam logic [11:0] SETTLE_CYC = 12'(`CSRC_XOSC_SETTLE_CYC);
	localparam logic [2:0] RESET_COMMAND_STROBE_CYC = 3'(`CSRC_RESET_COMMAND_STROBE_BUSY_CYC);

	logic rst_meta_q;
	logic rst_sync_q;
	logic cs_meta_q;
	logic cs_sync_q;
	logic soft_rst;
	csrc_pkg::csrc_state_e state_q;
	logic [11:0] settle_cnt_q;
	logic [2:0] reset_command_strobe_cnt_q;
	logic not_ready;
	logic signed [9:0] abs_thr;
	logic signed [9:0] rssi_ext;
	logic signed [9:0] prev_rssi_q;
	logic prev_valid_q;
	logic signed [9:0] rssi_delta;
	logic signed [9:0] rel_step;
	logic abs_flag_q;
	logic rel_flag_q;
	logic carrier;
	logic [5:0] selector_q;
	logic [7:0] div_cnt_q;
	logic div_clk_q;
	logic div_tick;
	logic pin_zero_q;
	logic serial_q;
	logic [4:0] state_num;

	// reset released through two stages so every flop leaves reset together
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	// chip select arrives from the pin, asynchronous to mclk
	always_ff @(posedge i_mclk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			cs_meta_q <= 1'b1;
			cs_sync_q <= 1'b1;
		end else begin
			cs_meta_q <= i_chip_select_low_n;
			cs_sync_q <= cs_meta_q;
		end
	end

	assign soft_rst = i_reset_command_strobe;

	// oscillator settle after power-on; a reset strobe does not restart it
	always_ff @(posedge i_mclk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			settle_cnt_q <= 12'h000;
		end else if (settle_cnt_q != SETTLE_CYC) begin
			settle_cnt_q <= settle_cnt_q + 12'h001;
		end
	end

	// reset strobe keeps the device busy for a few cycles
	always_ff @(posedge i_mclk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			reset_command_strobe_cnt_q <= 3'h0;
		end else if (soft_rst) begin
			reset_command_strobe_cnt_q <= RESET_COMMAND_STROBE_CYC;
		end else if (reset_command_strobe_cnt_q != 3'h0) begin
			reset_command_strobe_cnt_q <= reset_command_strobe_cnt_q - 3'h1;
		end
	end

	// radio controller
	always_ff @(posedge i_mclk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			state_q <= csrc_pkg::CSRC_ST_STARTUP;
		end else if (soft_rst && state_q != csrc_pkg::CSRC_ST_STARTUP) begin
			state_q <= csrc_pkg::CSRC_ST_IDLE;
		end else begin
			unique case (state_q)
				csrc_pkg::CSRC_ST_STARTUP: begin
					if (settle_cnt_q == SETTLE_CYC) begin
						state_q <= csrc_pkg::CSRC_ST_IDLE;
					end
				end
				csrc_pkg::CSRC_ST_IDLE: begin
					if (i_cmd_rx) begin
						state_q <= csrc_pkg::CSRC_ST_RX;
					end
				end
				csrc_pkg::CSRC_ST_RX: begin
					if (i_cmd_idle) begin
						state_q <= csrc_pkg::CSRC_ST_IDLE;
					end else if (i_rx_fifo_overflow) begin
						state_q <= csrc_pkg::CSRC_ST_RX_OVF;
					end
				end
				csrc_pkg::CSRC_ST_RX_OVF: begin
					if (i_cmd_idle || i_cmd_flush_rx) begin
						state_q <= csrc_pkg::CSRC_ST_IDLE;
					end
				end
			endcase
		end
	end

	always_comb begin
		unique case (state_q)
			csrc_pkg::CSRC_ST_STARTUP: state_num = `CSRC_STNUM_STARTUP;
			csrc_pkg::CSRC_ST_IDLE: state_num = `CSRC_STNUM_IDLE;
			csrc_pkg::CSRC_ST_RX: state_num = `CSRC_STNUM_RX;
			csrc_pkg::CSRC_ST_RX_OVF: state_num = `CSRC_STNUM_RX_OVF;
		endcase
	end

	// the busy window holds the host off until defaults are back
	assign not_ready = (state_q == csrc_pkg::CSRC_ST_STARTUP) || (reset_command_strobe_cnt_q != 3'h0);

	// absolute threshold in raw rssi units
	function automatic logic signed [9:0] calc_abs_thr(input csrc_pkg::csrc_cfg_s c);
		int idx;
		int base;
		int lvl;
		idx = int'({c.front_gain_ceiling, c.digital_gain_ceiling});
		// goals nearer 42 dB use the upper table
		if (c.channel_level_goal >= `CSRC_GOAL_SPLIT) begin
			base = THR_GOAL7[idx];
		end else begin
			base = THR_GOAL3[idx];
		end
		// -8 is outside the documented span, clamp to -7
		if (c.absolute_detect_level == 4'h8) begin
			lvl = int'($signed(`CSRC_ABS_LEVEL_MIN));
		end else begin
			lvl = int'($signed(c.absolute_detect_level));
		end
		base = base + `CSRC_RSSI_OFFSET_HDB + 2 * lvl;
		return 10'(base);
	endfunction

	assign abs_thr = calc_abs_thr(i_cfg);
	assign rssi_ext = 10'($signed(i_rssi));
	assign rssi_delta = rssi_ext - prev_rssi_q;

	always_comb begin
		unique case (i_cfg.relative_detect_step)
			csrc_pkg::CSRC_REL_OFF: rel_step = `CSRC_REL_STEP_6DB;
			csrc_pkg::CSRC_REL_6DB: rel_step = `CSRC_REL_STEP_6DB;
			csrc_pkg::CSRC_REL_10DB: rel_step = `CSRC_REL_STEP_10DB;
			csrc_pkg::CSRC_REL_14DB: rel_step = `CSRC_REL_STEP_14DB;
		endcase
	end

	// previous sample for the relative detector
	always_ff @(posedge i_mclk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			prev_rssi_q <= 10'sh000;
			prev_valid_q <= 1'b0;
		end else if (soft_rst) begin
			prev_rssi_q <= 10'sh000;
			prev_valid_q <= 1'b0;
		end else if (i_rssi_valid) begin
			prev_rssi_q <= rssi_ext;
			prev_valid_q <= 1'b1;
		end
	end

	// absolute detector, only moves on a new sample or a reset strobe
	// hysteresis stops a level near threshold from chattering
	always_ff @(posedge i_mclk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			abs_flag_q <= 1'b0;
		end else if (soft_rst) begin
			abs_flag_q <= 1'b0;
		end else if (i_rssi_valid) begin
			if (rssi_ext > abs_thr) begin
				abs_flag_q <= 1'b1;
			end else if (rssi_ext < abs_thr - `CSRC_HYST_HDB) begin
				abs_flag_q <= 1'b0;
			end
		end
	end

	// relative detector ignores the absolute level
	// step off clears at once instead of waiting for a sample
	always_ff @(posedge i_mclk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			rel_flag_q <= 1'b0;
		end else if (soft_rst || i_cfg.relative_detect_step == csrc_pkg::CSRC_REL_OFF) begin
			rel_flag_q <= 1'b0;
		end else if (i_rssi_valid && prev_valid_q) begin
			if (rssi_delta >= rel_step) begin
				rel_flag_q <= 1'b1;
			end else if (rssi_delta <= -rel_step) begin
				rel_flag_q <= 1'b0;
			end
		end
	end

	assign carrier = abs_flag_q | rel_flag_q;

	// sync search only with carrier when the qualifier asks for it
	assign o_sync_search_en = (state_q == csrc_pkg::CSRC_ST_RX) &&
		(!i_cfg.modem_config_two_sync_mode[`CSRC_SYNC_CS_BIT] || carrier);

	// pin selector register, default restored by either reset
	always_ff @(posedge i_mclk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			selector_q <= `CSRC_SEL_RESET;
		end else if (soft_rst) begin
			selector_q <= `CSRC_SEL_RESET;
		end else if (i_output_pin_selector_wr) begin
			selector_q <= i_output_pin_selector;
		end
	end

	// divide by 192: one-cycle tick every 96 cycles toggles the pin clock
	always_ff @(posedge i_mclk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			div_cnt_q <= 8'h00;
		end else if (div_tick) begin
			div_cnt_q <= 8'h00;
		end else begin
			div_cnt_q <= div_cnt_q + 8'h01;
		end
	end

	assign div_tick = (div_cnt_q == `CSRC_CLK_HALF - 8'h01);

	always_ff @(posedge i_mclk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			div_clk_q <= 1'b0;
		end else if (div_tick) begin
			div_clk_q <= ~div_clk_q;
		end
	end

	// unsupported selector codes drive low
	always_ff @(posedge i_mclk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			pin_zero_q <= 1'b0;
		end else begin
			unique case (selector_q)
				`CSRC_SEL_CARRIER: pin_zero_q <= carrier;
				`CSRC_SEL_CLK192: pin_zero_q <= div_clk_q;
				default: pin_zero_q <= 1'b0;
			endcase
		end
	end

	// serial out shows not-ready while selected; high until ready
	always_ff @(posedge i_mclk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			serial_q <= 1'b1;
		end else begin
			serial_q <= not_ready;
		end
	end

	assign o_serial_out = serial_q;
	assign o_serial_out_oe = !cs_sync_q;
	assign o_general_output_pin_zero = pin_zero_q;
	assign o_output_pin_selector = selector_q;
	always_comb begin
		o_status = '0;
		o_status.controller_state_number = state_num;
		o_status.packet_status_carrier_bit = carrier;
		o_status.device_not_ready_flag = serial_q;
	end

endmodule // csrc_core
`default_nettype wire

// ==== testbench/csrc_core_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module csrc_core_chk (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire csrc_pkg::csrc_cfg_s i_cfg,
	input wire logic i_rssi_valid,
	input wire logic i_reset_command_strobe,
	input wire logic i_cmd_rx,
	input wire logic i_cmd_idle,
	input wire logic i_rx_fifo_overflow,
	input wire logic i_chip_select_low_n,
	input wire logic o_serial_out,
	input wire logic o_serial_out_oe,
	input wire logic o_general_output_pin_zero,
	input wire logic [5:0] o_output_pin_selector,
	input wire logic o_sync_search_en,
	input wire csrc_pkg::csrc_status_s o_status
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_reset_n);
	wire logic [4:0] st = o_status.controller_state_number;
	wire logic car = o_status.packet_status_carrier_bit;
	property p_oe;
		!i_chip_select_low_n [*3] |-> o_serial_out_oe;
	endproperty
	a_oe: assert property (p_oe) else $error("oe late");
	property p_mir;
		o_serial_out == o_status.device_not_ready_flag && (st != 5'h00 || o_serial_out);
	endproperty
	a_mir: assert property (p_mir) else $error("ready mirror");
	property p_pin;
		o_output_pin_selector == 6'h0E ##1 o_output_pin_selector == 6'h0E |-> o_general_output_pin_zero == $past(car);
	endproperty
	a_pin: assert property (p_pin) else $error("pin carrier");
	property p_sync;
		o_sync_search_en |-> st == 5'h0D && (!i_cfg.modem_config_two_sync_mode[2] || car);
	endproperty
	a_sync: assert property (p_sync) else $error("sync gate");
	property p_rx;
		st == 5'h01 && i_cmd_rx && !i_reset_command_strobe |=> st == 5'h0D;
	endproperty
	a_rx: assert property (p_rx) else $error("rx entry");
	property p_ovf;
		st == 5'h0D && i_rx_fifo_overflow && !i_cmd_idle && !i_reset_command_strobe |=> st == 5'h11;
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow");
	// busy window must end, or the host would wait forever
	property p_reset_command_strobe;
		i_reset_command_strobe && st != 5'h00 |=> st == 5'h01 && o_output_pin_selector == 6'h3F
			##1 o_serial_out [*4] ##1 !o_serial_out;
	endproperty
	a_reset_command_strobe: assert property (p_reset_command_strobe) else $error("reset strobe");
	property p_hold;
		!$past(i_rssi_valid) && !$past(i_reset_command_strobe) && $past(i_cfg) == $past(i_cfg, 2) |-> $stable(car);
	endproperty
	a_hold: assert property (p_hold) else $error("carrier moved");
endmodule // csrc_core_chk
bind csrc_core csrc_core_chk i_chk (.i_mclk, .i_reset_n, .i_cfg, .i_rssi_valid, .i_reset_command_strobe,
	.i_cmd_rx, .i_cmd_idle, .i_rx_fifo_overflow, .i_chip_select_low_n, .o_serial_out, .o_serial_out_oe,
	.o_general_output_pin_zero, .o_output_pin_selector, .o_sync_search_en, .o_status);
`default_nettype wire

// ==== testbench/csrc_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module csrc_host (
	input wire logic i_mclk,
	input wire logic i_so,
	input wire logic i_so_oe,
	output logic o_cs_n,
	output logic o_reset_command_strobe
);
	int n;
	initial begin
		o_cs_n = 1'b1;
		o_reset_command_strobe = 1'b0;
	end
	// full sequence only after power-up
	task automatic power_up(output logic busy, output logic ok);
		logic hi;
		@(posedge i_mclk) #1 o_cs_n = 1'b0;
		@(posedge i_mclk) #1 o_cs_n = 1'b1;
		repeat (800) @(posedge i_mclk);
		#1 o_cs_n = 1'b0;
		repeat (3) @(posedge i_mclk);
		#1 busy = i_so_oe && i_so;
		for (n = 0; n < 3000 && !(i_so_oe && !i_so); n++) @(posedge i_mclk) #1;
		ok = !i_so;
		o_reset_command_strobe = 1'b1;
		@(posedge i_mclk) #1 o_reset_command_strobe = 1'b0;
		for (n = 0; n < 9 && !i_so; n++) @(posedge i_mclk) #1;
		hi = i_so;
		for (n = 0; n < 9 && i_so; n++) @(posedge i_mclk) #1;
		ok = ok && hi && !i_so;
		// deselect so the next power reset never sees a stale select
		o_cs_n = 1'b1;
	endtask
	// any later reset is the strobe alone
	task automatic strobe;
		o_reset_command_strobe = 1'b1;
		@(posedge i_mclk) #1 o_reset_command_strobe = 1'b0;
	endtask
	// device already settled: serial out shows ready at once
	task automatic select(output logic ok);
		o_cs_n = 1'b0;
		repeat (3) @(posedge i_mclk);
		#1 ok = i_so_oe && !i_so;
		o_cs_n = 1'b1;
	endtask
endmodule // csrc_host
`default_nettype wire

// ==== testbench/csrc_core_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin errors++; \
	$display("wrong value %s exp %0h got %0h", n, e, a); end end
module csrc_core_tb;
	logic i_mclk, i_reset_n, vld, reset_command_strobe, cs_n, rx, idl, fl, ov, wr, so, oe, pin, sse, busy, ok;
	logic [7:0] rssi;
	logic [5:0] sel, sel_o;
	csrc_pkg::csrc_cfg_s cfg;
	csrc_pkg::csrc_status_s st;
	int errors, tests_run, seed, p, k, n, thr, stp, prev, ab, rl, pv;
	csrc_core i_dut (.i_mclk, .i_reset_n, .i_cfg(cfg), .i_rssi_valid(vld), .i_rssi(rssi),
		.i_reset_command_strobe(reset_command_strobe), .i_cmd_rx(rx), .i_cmd_idle(idl), .i_cmd_flush_rx(fl),
		.i_rx_fifo_overflow(ov), .i_output_pin_selector_wr(wr), .i_output_pin_selector(sel),
		.i_chip_select_low_n(cs_n), .o_serial_out(so), .o_serial_out_oe(oe), .o_general_output_pin_zero(pin),
		.o_output_pin_selector(sel_o), .o_sync_search_en(sse), .o_status(st));
	csrc_host i_host (.i_mclk, .i_so(so), .i_so_oe(oe), .o_cs_n(cs_n), .o_reset_command_strobe(reset_command_strobe));
	initial begin
		i_mclk = 1'b0;
		forever #25 i_mclk = ~i_mclk;
	end
	task automatic summarize;
		if (errors == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic tick;
		@(posedge i_mclk);
		#1;
	endtask
	task automatic cmd(input logic [3:0] c, input logic [4:0] e);
		{rx, idl, fl, ov} = c;
		tick;
		{rx, idl, fl, ov} = 4'h0;
		`CHK("state", e, st.controller_state_number)
		// let an edge pass so the next strobe is a fresh request
		tick;
	endtask
	// level -8 clamps to -7; higher ceilings give the higher raw figure
	function automatic int thr_f(logic g, logic [3:0] lv);
		int l;
		l = $signed(lv);
		if (l < -7) l = -7;
		return (g ? 36 : -47) + 2 * l;
	endfunction
	initial begin
		#3000000;
		errors++;
		summarize();
	end
	initial begin
		seed = 89846;
		{vld, rx, idl, fl, ov, wr, i_reset_n} = 7'h00;
		rssi = 8'h00;
		sel = 6'h00;
		cfg = '0;
		for (p = 0; p < 8; p++) begin
			i_reset_n = 1'b0;
			cfg = 17'($random(seed));
			cfg.relative_detect_step = csrc_pkg::csrc_rel_step_e'(p % 4);
			cfg.front_gain_ceiling = p > 3 ? 3'h7 : 3'h0;
			cfg.digital_gain_ceiling = p > 3 ? 2'h3 : 2'h0;
			cfg.modem_config_two_sync_mode[2] = p[1] ^ p[2];
			cfg.channel_level_goal = p > 3 ? 3'h7 : 3'h3;
			repeat (6) @(posedge i_mclk);
			#1 i_reset_n = 1'b1;
			`CHK("sel", 6'h3F, sel_o)
			i_host.power_up(busy, ok);
			`CHK("busy", 1'b1, busy)
			`CHK("ready", 1'b1, ok)
			`CHK("state", 5'h01, st.controller_state_number)
			if (p == 0) begin
				for (n = 0; n < 400 && pin; n++) tick;
				for (n = 0; n < 400 && !pin; n++) tick;
				for (n = 0; n < 400 && pin; n++) tick;
				`CHK("div", 96, n)
			end
			cmd(4'h8, 5'h0D);
			sel = 6'h0E;
			wr = 1'b1;
			tick;
			wr = 1'b0;
			`CHK("sel", 6'h0E, sel_o)
			ab = 0;
			rl = 0;
			pv = 0;
			thr = thr_f(p > 3, cfg.absolute_detect_level);
			stp = 4 + 8 * (p % 4);
			for (k = 0; k < 60; k++) begin
				vld = k < 3 || ($random(seed) & 3) != 0;
				rssi = 8'(k < 3 ? thr + 1 - 2 * k : thr + $random(seed) % 40);
				tick;
				if (vld) begin
					n = $signed(rssi);
					if (n > thr) ab = 1;
					else if (n < thr - 2) ab = 0;
					if (pv != 0 && p % 4 != 0 && n - prev >= stp) rl = 1;
					else if (pv != 0 && p % 4 != 0 && prev - n >= stp) rl = 0;
					pv = 1;
					prev = n;
				end
				`CHK("carrier", 1'(ab | rl), st.packet_status_carrier_bit)
				`CHK("search", 1'(!cfg.modem_config_two_sync_mode[2] || ab || rl), sse)
			end
			vld = 1'b0;
			sel = 6'h01;
			wr = 1'b1;
			tick;
			wr = 1'b0;
			tick;
			`CHK("pin", 1'b0, pin)
			cmd(4'h1, 5'h11);
			cmd(4'h8, 5'h11);
			cmd(4'h4, 5'h01);
			cmd(4'h2, 5'h01);
			cmd(4'h8, 5'h0D);
			cmd(4'h5, 5'h01);
			cmd(4'h8, 5'h0D);
			cmd(4'h1, 5'h11);
			cmd(4'h2, 5'h01);
			cmd(4'h8, 5'h0D);
			i_host.strobe();
			`CHK("state", 5'h01, st.controller_state_number)
			`CHK("sel", 6'h3F, sel_o)
			`CHK("carrier", 1'b0, st.packet_status_carrier_bit)
			`CHK("search", 1'b0, sse)
			for (n = 0; n < 9 && !so; n++) tick;
			for (n = 0; n < 9 && so; n++) tick;
			`CHK("busy", 4, n)
			i_host.select(ok);
			`CHK("ready", 1'b1, ok)
		end
		summarize();
	end
endmodule // csrc_core_tb
`default_nettype wire
